/* design/logic_cell_pkg.sv */
// Purpose: Shared constants and types for the configurable logic cell
// Assumes: APB register slave, 32-bit data, one register per aligned word
// Notes:   Registers are 16 bits wide and sit in the low half of each word

package logic_cell_pkg;

   // ------------------------------------------------------------
   // Bus and register map
   // ------------------------------------------------------------
   localparam int          ADDR_W        = 8;
   localparam int          DATA_W        = 32;
   localparam int          REG_W         = 16;
   localparam logic [7:0]  OFS_CTL_LOW   = 8'h00;
   localparam logic [7:0]  OFS_GATE_POL  = 8'h04;
   localparam logic [7:0]  OFS_SRC_SEL   = 8'h08;
   localparam logic [7:0]  OFS_GEN_LOW   = 8'h0C;
   localparam logic [7:0]  OFS_GEN_HIGH  = 8'h10;
   localparam logic [7:0]  OFS_IRQ_STAT  = 8'h14;
   localparam logic [7:0]  OFS_IRQ_MASK  = 8'h18;

   // ------------------------------------------------------------
   // Field positions, write masks and reset values
   // ------------------------------------------------------------
   localparam int          CTL_EN_BIT    = 15;
   localparam int          CTL_RISE_BIT  = 11;
   localparam int          CTL_FALL_BIT  = 10;
   localparam int          CTL_OE_BIT    = 7;
   localparam int          CTL_STATE_BIT = 6;
   localparam int          CTL_INV_BIT   = 5;
   localparam int          MODE_LSB      = 0;
   localparam int          MODE_W        = 3;
   localparam logic [15:0] CTL_WMASK     = 16'h8CA7;
   localparam logic [15:0] CTL_RESET     = 16'h0000;
   localparam logic [15:0] SEL_WMASK     = 16'h7777;
   localparam logic [15:0] SEL_RESET     = 16'h0000;
   localparam logic [15:0] GEN_RESET     = 16'h0000;
   localparam int          N_MUX         = 4;
   localparam int          N_SRC         = 8;
   localparam int          SEL_W         = 3;
   localparam int          SEL_STRIDE    = 4;
   localparam logic [3:0]  GPOL_RESET    = 4'h0;
   localparam int          IRQ_W         = 2;
   localparam int          IRQ_RISE_BIT  = 0;
   localparam int          IRQ_FALL_BIT  = 1;
   localparam logic [1:0]  IRQ_RESET     = 2'h0;

   // ------------------------------------------------------------
   // Cell functions
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      MODE_AND_OR  = 3'b000,
      MODE_OR_XOR  = 3'b001,
      MODE_AND4    = 3'b010,
      MODE_SR      = 3'b011,
      MODE_DFF_SR  = 3'b100,
      MODE_DFF2_R  = 3'b101,
      MODE_JK_R    = 3'b110,
      MODE_LATCH   = 3'b111
   } mode_e;

endpackage

/* design/logic_cell.sv */
// Purpose: Configurable logic cell with APB registers and edge interrupts
// Assumes: All source inputs are synchronous to pclk
// Notes:   Stored functions are evaluated once per pclk; gate 1 acts as clock in codes 100-110 and as enable in latch mode
//
// Functional notes
// - Enable clear forces cell output low
// - Rising output edge raises interrupt when enabled
// - Falling output edge raises interrupt when enabled
// - Pin driven only while pin enable set
// - Output state bit is read-only level
// - Output invert bit inverts final output
// - Codes 000-010 select combinational functions
// - Codes 100-110 select flip-flop functions
// - Codes 011 and 111 select latches
// - Four gates fed from 32-signal pool
// - Each mux picks one of eight
// - Each mux gives true and inverted copies
// - Gate ORs its enabled mux signals
// - Result feeds peripherals and pin, autonomously
// - Writable bits reset zero, unused read zero
// - Per-gate polarity bit inverts gate output
// - True and inverted enable per gate source

module logic_cell (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic [31:0] src_in,
   output logic             cell_out,
   output logic             pin_out,
   output logic             pin_oe_n,
   output logic             irq
);

   // ------------------------------------------------------------
   // Registers and state
   // ------------------------------------------------------------
   logic [15:0]   ctl_reg;
   logic [3:0]    gpol_reg;
   logic [15:0]   sel_reg;
   logic [15:0]   gen_lo_reg;
   logic [15:0]   gen_hi_reg;
   logic [1:0]    irq_stat_reg;
   logic [1:0]    irq_stat_next;
   logic [1:0]    irq_mask_reg;
   logic          state_reg;
   logic          state_next;
   logic          g1_prev_reg;
   logic          cell_out_reg;
   logic          cell_next;
   logic          pin_out_reg;
   logic          pin_oe_n_reg;
   logic          rise_pulse_reg;
   logic          fall_pulse_reg;
   logic          irq_reg;
   logic          pready_reg;
   logic          pslverr_reg;
   logic [31:0]   prdata_reg;

   logic          wr_en;
   logic          rd_hit;
   logic [15:0]   rd_val;
   logic [15:0]   wdata;
   logic [31:0]   gen_all;
   logic [3:0]    mux_val;
   logic [7:0]    pair_vec;
   logic [3:0]    gate_raw;
   logic [3:0]    gate_val;
   logic          raw_val;
   logic          g1_rise;
   logic_cell_pkg::mode_e mode;
   logic          cell_en;
   logic          out_inv;

   assign wdata   = pwdata[15:0];
   assign wr_en   = psel & penable & pready_reg & pwrite;
   assign gen_all = {gen_hi_reg, gen_lo_reg};
   assign mode    = logic_cell_pkg::mode_e'(ctl_reg[logic_cell_pkg::MODE_LSB +: logic_cell_pkg::MODE_W]);
   assign cell_en = ctl_reg[logic_cell_pkg::CTL_EN_BIT];
   assign out_inv = ctl_reg[logic_cell_pkg::CTL_INV_BIT];

   // ------------------------------------------------------------
   // Input muxes and gates
   // ------------------------------------------------------------
   // Pool of 32: mux m owns src_in[8m+7:8m]
   for (genvar m = 0; m < logic_cell_pkg::N_MUX; m++) begin : g_mux
      assign mux_val[m] = src_in[m * logic_cell_pkg::N_SRC +
                                 sel_reg[m * logic_cell_pkg::SEL_STRIDE +: logic_cell_pkg::SEL_W]];
      assign pair_vec[2 * m + 1] = mux_val[m];
      assign pair_vec[2 * m]     = ~mux_val[m];
   end

   for (genvar g = 0; g < logic_cell_pkg::N_MUX; g++) begin : g_gate
      // Odd enable bits admit true copies, even ones the inverted copies
      assign gate_raw[g] = |(gen_all[g * 8 +: 8] & pair_vec);
      assign gate_val[g] = gate_raw[g] ^ gpol_reg[g];
   end

   assign g1_rise = gate_val[0] & ~g1_prev_reg;

   // ------------------------------------------------------------
   // Cell function
   // ------------------------------------------------------------
   // Clocked modes: gate 1 clock, gate 2 data/J, gate 3 reset, gate 4 set/data/K; latch: gate 1 enable, else the same.
   // Reset beats set, since a stuck-high set would otherwise lock the cell.
   always_comb begin
      state_next = state_reg;
      raw_val    = 1'b0;
      unique case (mode)
         logic_cell_pkg::MODE_AND_OR: begin
            raw_val = (gate_val[0] & gate_val[1]) | (gate_val[2] & gate_val[3]);
         end
         logic_cell_pkg::MODE_OR_XOR: begin
            raw_val = (gate_val[0] | gate_val[1]) ^ (gate_val[2] | gate_val[3]);
         end
         logic_cell_pkg::MODE_AND4: begin
            raw_val = &gate_val;
         end
         logic_cell_pkg::MODE_SR: begin
            if (gate_val[2] | gate_val[3]) begin
               state_next = 1'b0;
            end else if (gate_val[0] | gate_val[1]) begin
               state_next = 1'b1;
            end
            raw_val = state_next;
         end
         logic_cell_pkg::MODE_DFF_SR: begin
            if (gate_val[2]) begin
               state_next = 1'b0;
            end else if (gate_val[3]) begin
               state_next = 1'b1;
            end else if (g1_rise) begin
               state_next = gate_val[1];
            end
            raw_val = state_next;
         end
         logic_cell_pkg::MODE_DFF2_R: begin
            if (gate_val[2]) begin
               state_next = 1'b0;
            end else if (g1_rise) begin
               state_next = gate_val[1] & gate_val[3];
            end
            raw_val = state_next;
         end
         logic_cell_pkg::MODE_JK_R: begin
            if (gate_val[2]) begin
               state_next = 1'b0;
            end else if (g1_rise) begin
               unique case ({gate_val[1], gate_val[3]})
                  2'b10:   state_next = 1'b1;
                  2'b01:   state_next = 1'b0;
                  2'b11:   state_next = ~state_reg;
                  2'b00:   state_next = state_reg;
               endcase
            end
            raw_val = state_next;
         end
         logic_cell_pkg::MODE_LATCH: begin
            if (gate_val[2]) begin
               state_next = 1'b0;
            end else if (gate_val[3]) begin
               state_next = 1'b1;
            end else if (gate_val[0]) begin
               state_next = gate_val[1];
            end
            raw_val = state_next;
         end
      endcase
      if (!cell_en) begin
         state_next = 1'b0;
      end
   end

   assign cell_next = cell_en & (raw_val ^ out_inv);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg   <= 1'b0;
         g1_prev_reg <= 1'b0;
      end else begin
         state_reg   <= state_next;
         g1_prev_reg <= gate_val[0];
      end
   end

   // ------------------------------------------------------------
   // Outputs to peripherals and pin
   // ------------------------------------------------------------
   // Runs every cycle with no software involvement
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cell_out_reg <= 1'b0;
         pin_out_reg  <= 1'b0;
         pin_oe_n_reg <= 1'b1;
      end else begin
         cell_out_reg <= cell_next;
         pin_out_reg  <= cell_next & ctl_reg[logic_cell_pkg::CTL_OE_BIT];
         pin_oe_n_reg <= ~ctl_reg[logic_cell_pkg::CTL_OE_BIT];
      end
   end

   // ------------------------------------------------------------
   // Edge interrupts
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rise_pulse_reg <= 1'b0;
         fall_pulse_reg <= 1'b0;
      end else begin
         rise_pulse_reg <= ctl_reg[logic_cell_pkg::CTL_RISE_BIT] & cell_next & ~cell_out_reg;
         fall_pulse_reg <= ctl_reg[logic_cell_pkg::CTL_FALL_BIT] & ~cell_next & cell_out_reg;
      end
   end

   // Set wins over a same-cycle write-one-to-clear
   always_comb begin
      irq_stat_next = irq_stat_reg;
      if (wr_en && paddr == logic_cell_pkg::OFS_IRQ_STAT) begin
         irq_stat_next = irq_stat_reg & ~wdata[1:0];
      end
      irq_stat_next[logic_cell_pkg::IRQ_RISE_BIT] = irq_stat_next[logic_cell_pkg::IRQ_RISE_BIT] | rise_pulse_reg;
      irq_stat_next[logic_cell_pkg::IRQ_FALL_BIT] = irq_stat_next[logic_cell_pkg::IRQ_FALL_BIT] | fall_pulse_reg;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_stat_reg <= logic_cell_pkg::IRQ_RESET;
         irq_reg      <= 1'b0;
      end else begin
         irq_stat_reg <= irq_stat_next;
         irq_reg      <= |(irq_stat_next & irq_mask_reg);
      end
   end

   // ------------------------------------------------------------
   // Register writes
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctl_reg      <= logic_cell_pkg::CTL_RESET;
         gpol_reg     <= logic_cell_pkg::GPOL_RESET;
         sel_reg      <= logic_cell_pkg::SEL_RESET;
         gen_lo_reg   <= logic_cell_pkg::GEN_RESET;
         gen_hi_reg   <= logic_cell_pkg::GEN_RESET;
         irq_mask_reg <= logic_cell_pkg::IRQ_RESET;
      end else if (wr_en) begin
         unique case (paddr)
            logic_cell_pkg::OFS_CTL_LOW:  ctl_reg      <= wdata & logic_cell_pkg::CTL_WMASK;
            logic_cell_pkg::OFS_GATE_POL: gpol_reg     <= wdata[3:0];
            logic_cell_pkg::OFS_SRC_SEL:  sel_reg      <= wdata & logic_cell_pkg::SEL_WMASK;
            logic_cell_pkg::OFS_GEN_LOW:  gen_lo_reg   <= wdata;
            logic_cell_pkg::OFS_GEN_HIGH: gen_hi_reg   <= wdata;
            logic_cell_pkg::OFS_IRQ_MASK: irq_mask_reg <= wdata[1:0];
            default: ;
         endcase
      end
   end

   // ------------------------------------------------------------
   // Register reads and APB answer
   // ------------------------------------------------------------
   always_comb begin
      rd_hit = 1'b1;
      rd_val = 16'h0000;
      unique case (paddr)
         logic_cell_pkg::OFS_CTL_LOW: begin
            rd_val = ctl_reg;
            rd_val[logic_cell_pkg::CTL_STATE_BIT] = cell_out_reg;
         end
         logic_cell_pkg::OFS_GATE_POL: rd_val = {12'h000, gpol_reg};
         logic_cell_pkg::OFS_SRC_SEL:  rd_val = sel_reg;
         logic_cell_pkg::OFS_GEN_LOW:  rd_val = gen_lo_reg;
         logic_cell_pkg::OFS_GEN_HIGH: rd_val = gen_hi_reg;
         logic_cell_pkg::OFS_IRQ_STAT: rd_val = {14'h0000, irq_stat_reg};
         logic_cell_pkg::OFS_IRQ_MASK: rd_val = {14'h0000, irq_mask_reg};
         default:                      rd_hit = 1'b0;
      endcase
   end

   // No wait state: ready rises in the first access cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_reg  <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg  <= 32'h00000000;
      end else begin
         pready_reg <= psel & ~penable;
         if (psel && !penable) begin
            pslverr_reg <= ~rd_hit;
            prdata_reg  <= pwrite ? 32'h00000000 : {16'h0000, rd_val};
         end else begin
            pslverr_reg <= 1'b0;
            prdata_reg  <= 32'h00000000;
         end
      end
   end

   assign prdata   = prdata_reg;
   assign pready   = pready_reg;
   assign pslverr  = pslverr_reg;
   assign cell_out = cell_out_reg;
   assign pin_out  = pin_out_reg;
   assign pin_oe_n = pin_oe_n_reg;
   assign irq      = irq_reg;

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   AST_DISABLED_LOW: assert property (!cell_en |=> !cell_out_reg)
      else $error("cell output high while disabled");

   AST_RISE_IRQ: assert property ($rose(cell_out_reg) && $past(ctl_reg[logic_cell_pkg::CTL_RISE_BIT])
                                  |-> rise_pulse_reg ##1 irq_stat_reg[logic_cell_pkg::IRQ_RISE_BIT])
      else $error("rising edge did not set status");

   AST_FALL_IRQ: assert property ($fell(cell_out_reg) && $past(ctl_reg[logic_cell_pkg::CTL_FALL_BIT])
                                  |-> fall_pulse_reg ##1 irq_stat_reg[logic_cell_pkg::IRQ_FALL_BIT])
      else $error("falling edge did not set status");

   AST_PIN_OFF: assert property (!ctl_reg[logic_cell_pkg::CTL_OE_BIT] |=> pin_oe_n_reg && !pin_out_reg)
      else $error("pin driven while disabled");

   AST_STATE_READ: assert property (psel && !penable && !pwrite && paddr == logic_cell_pkg::OFS_CTL_LOW
                                    |=> prdata_reg[logic_cell_pkg::CTL_STATE_BIT] == $past(cell_out_reg))
      else $error("state bit differs from output");

   AST_INVERT: assert property (cell_en && out_inv && mode == logic_cell_pkg::MODE_AND4 && &gate_val
                                |=> !cell_out_reg)
      else $error("inverted output not low");

   AST_AND4: assert property (cell_en && !out_inv && mode == logic_cell_pkg::MODE_AND4
                              |=> cell_out_reg == $past(&gate_val))
      else $error("four-input AND wrong");

   AST_AND_OR: assert property (cell_en && !out_inv && mode == logic_cell_pkg::MODE_AND_OR
                                |=> cell_out_reg == $past((gate_val[0] & gate_val[1]) |
                                                          (gate_val[2] & gate_val[3])))
      else $error("AND-OR output wrong");

   AST_DFF_RESET: assert property (cell_en && !out_inv && gate_val[2] && mode == logic_cell_pkg::MODE_JK_R
                                   |=> !cell_out_reg)
      else $error("flip-flop reset ignored");

   COV_RISE_IRQ: cover property (rise_pulse_reg ##1 irq_reg);
   COV_FALL_IRQ: cover property (fall_pulse_reg ##1 irq_reg);
   COV_JK_TOGGLE: cover property (mode == logic_cell_pkg::MODE_JK_R && cell_en ##1 $changed(cell_out_reg));
   COV_PIN_DRIVE: cover property (!pin_oe_n_reg && pin_out_reg);

endmodule

/* testbench/peer_signals.sv */
// Purpose: Far-side model: peripheral source pool and the cell's pad
// Assumes: Sources are synchronous to pclk; the pad has a pull-up
// Notes:   A released pad reads high, so a stuck driver shows up

module peer_signals (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic [31:0] src_next,
   input  wire logic        pin_out,
   input  wire logic        pin_oe_n,
   output logic      [31:0] src_in,
   output logic             pin_level
);
   timeunit 1ns;
   timeprecision 1ps;

   // Peripherals launch their signals from pclk like any other flop
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         src_in <= 32'h0;
      else
         src_in <= src_next;
   end

   // Pull-up holds the pad while the cell lets go of it
   assign pin_level = pin_oe_n ? 1'h1 : pin_out;
endmodule

/* testbench/tb_top.sv */
// Purpose: Self-checking bench for the configurable logic cell
// Assumes: APB answer within 20 cycles; partner registers the pool
// Notes:   Gate g mostly wired to source bit 9g through its own mux

module tb_top;
   timeunit 1ns;
   timeprecision 1ps;

   logic        pclk = 1'h0;
   logic        presetn = 1'h0;
   logic        psel = 1'h0;
   logic        penable = 1'h0;
   logic        pwrite = 1'h0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] src_next = 32'h0;
   logic [31:0] prdata;
   logic [31:0] src_in;
   logic        pready;
   logic        pslverr;
   logic        cell_out;
   logic        pin_out;
   logic        pin_oe_n;
   logic        irq;
   logic        pin_level;
   int          n_mismatch = 0;
   int          checked = 0;

   always #12.5 pclk = ~pclk;

   logic_cell dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .src_in(src_in), .cell_out(cell_out), .pin_out(pin_out),
      .pin_oe_n(pin_oe_n), .irq(irq));
   peer_signals peer (.pclk(pclk), .presetn(presetn), .src_next(src_next),
      .pin_out(pin_out), .pin_oe_n(pin_oe_n), .src_in(src_in), .pin_level(pin_level));

   // ------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------
   task automatic conclude();
      if (n_mismatch == 0 && checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic apb(input logic wr, input logic [7:0] a, input logic [15:0] wd,
                      output logic [31:0] rd, output logic err);
      int n;
      @(posedge pclk);
      psel    <= 1'h1;
      penable <= 1'h0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= {16'h0000, wd};
      @(posedge pclk);
      penable <= 1'h1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'h1 && n < 20);
      rd = prdata;
      err = pslverr;
      psel    <= 1'h0;
      penable <= 1'h0;
      if (pready !== 1'h1) begin
         n_mismatch++;
         conclude();
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      logic [31:0] rd;
      logic        e;
      apb(1'h1, a, d, rd, e);
   endtask

   task automatic rdc(input string nm, input logic [7:0] a, input logic [15:0] x);
      logic [31:0] rd;
      logic        e;
      apb(1'h0, a, 16'h0000, rd, e);
      chk(nm, rd, {16'h0000, x});
      chk("pslverr", {31'h0, e}, 32'h0);
   endtask

   // Control goes to zero first so stored state starts clean
   task automatic cfg(input logic [15:0] c, p, s, l, h);
      wr(logic_cell_pkg::OFS_CTL_LOW, 16'h0000);
      wr(logic_cell_pkg::OFS_GATE_POL, p);
      wr(logic_cell_pkg::OFS_SRC_SEL, s);
      wr(logic_cell_pkg::OFS_GEN_LOW, l);
      wr(logic_cell_pkg::OFS_GEN_HIGH, h);
      wr(logic_cell_pkg::OFS_CTL_LOW, c);
   endtask

   task automatic put(input logic [31:0] v);
      @(posedge pclk);
      src_next <= v;
      repeat (3) @(posedge pclk);
      #1;
   endtask

   function automatic logic [31:0] vec(input logic [3:0] v);
      return {4'h0, v[3], 8'h00, v[2], 8'h00, v[1], 8'h00, v[0]};
   endfunction

   function automatic logic fn(input logic [2:0] m, input logic [3:0] g);
      case (m)
         3'h0: return (g[0] & g[1]) | (g[2] & g[3]);
         3'h1: return (g[0] | g[1]) ^ (g[2] | g[3]);
         default: return &g;
      endcase
   endfunction

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_regs();
      logic [31:0] rd;
      logic        e;
      for (int i = 0; i < 7; i++)
         rdc("reset value", 8'(4 * i), 16'h0000);
      apb(1'h1, 8'h40, 16'hFFFF, rd, e);
      chk("unmapped write err", {31'h0, e}, 32'h1);
      apb(1'h0, 8'h40, 16'h0000, rd, e);
      chk("unmapped read err", {31'h0, e}, 32'h1);
      chk("unmapped read data", rd, 32'h0);
      wr(logic_cell_pkg::OFS_CTL_LOW, 16'h7FFF);
      rdc("control", logic_cell_pkg::OFS_CTL_LOW, 16'h0CA7);
      wr(logic_cell_pkg::OFS_SRC_SEL, 16'hFFFF);
      rdc("select", logic_cell_pkg::OFS_SRC_SEL, 16'h7777);
      wr(logic_cell_pkg::OFS_GATE_POL, 16'hFFFF);
      rdc("gate polarity", logic_cell_pkg::OFS_GATE_POL, 16'h000F);
      wr(logic_cell_pkg::OFS_GEN_HIGH, 16'hFFFF);
      rdc("gate enables", logic_cell_pkg::OFS_GEN_HIGH, 16'hFFFF);
      wr(logic_cell_pkg::OFS_CTL_LOW, 16'h0000);
   endtask

   task automatic t_comb();
      logic [3:0] gp;
      logic       x;
      for (int m = 0; m < 3; m++)
         for (int iv = 0; iv < 2; iv++) begin
            gp = iv[0] ? 4'h5 : 4'h0;
            cfg(16'h8000 | 16'(m) | (iv[0] ? 16'h00A0 : 16'h0000), {12'h000, gp},
                16'h3210, 16'h0802, 16'h8020);
            for (int v = 0; v < 16; v++) begin
               put(vec(4'(v)));
               x = fn(3'(m), 4'(v) ^ gp) ^ iv[0];
               chk("cell_out", {31'h0, cell_out}, {31'h0, x});
               chk("pin_out", {31'h0, pin_out}, {31'h0, x & iv[0]});
               chk("pin_oe_n", {31'h0, pin_oe_n}, {31'h0, ~iv[0]});
            end
         end
   endtask

   task automatic t_neg();
      cfg(16'h8000, 16'h0002, 16'h3210, 16'h0009, 16'h0000);
      for (int v = 0; v < 4; v++) begin
         put(vec(4'(v)));
         chk("negated source", {31'h0, cell_out}, {31'h0, ~v[0] | v[1]});
      end
   endtask

   task automatic t_sel();
      for (int m = 0; m < 4; m++)
         for (int s = 0; s < 8; s++) begin
            cfg(16'h8000, 16'h0002, 16'(s << (4 * m)), 16'(2 << (2 * m)), 16'h0000);
            put(32'h1 << (8 * m + s));
            chk("mux pick", {31'h0, cell_out}, 32'h1);
            put(~(32'h1 << (8 * m + s)));
            chk("mux other", {31'h0, cell_out}, 32'h0);
         end
   endtask

   task automatic t_en();
      cfg(16'h8082, 16'h000F, 16'h0000, 16'h0000, 16'h0000);
      put(32'h0);
      chk("enabled out", {31'h0, cell_out}, 32'h1);
      chk("pad high", {31'h0, pin_level}, 32'h1);
      rdc("state bit", logic_cell_pkg::OFS_CTL_LOW, 16'h80C2);
      wr(logic_cell_pkg::OFS_CTL_LOW, 16'h80A2);
      put(32'h0);
      chk("pad low", {31'h0, pin_level}, 32'h0);
      wr(logic_cell_pkg::OFS_CTL_LOW, 16'h00A2);
      put(32'h0);
      chk("disabled out", {31'h0, cell_out}, 32'h0);
      rdc("disabled state", logic_cell_pkg::OFS_CTL_LOW, 16'h00A2);
   endtask

   task automatic t_irq();
      cfg(16'h8800, 16'h0002, 16'h0000, 16'h0002, 16'h0000);
      put(32'h0);
      wr(logic_cell_pkg::OFS_IRQ_STAT, 16'h0003);
      wr(logic_cell_pkg::OFS_IRQ_MASK, 16'h0003);
      put(32'h1);
      rdc("rise status", logic_cell_pkg::OFS_IRQ_STAT, 16'h0001);
      chk("irq raised", {31'h0, irq}, 32'h1);
      wr(logic_cell_pkg::OFS_IRQ_STAT, 16'h0001);
      put(32'h0);
      chk("irq cleared", {31'h0, irq}, 32'h0);
      rdc("fall off", logic_cell_pkg::OFS_IRQ_STAT, 16'h0000);
      wr(logic_cell_pkg::OFS_CTL_LOW, 16'h8C00);
      put(32'h1);
      put(32'h0);
      rdc("both edges", logic_cell_pkg::OFS_IRQ_STAT, 16'h0003);
      wr(logic_cell_pkg::OFS_IRQ_MASK, 16'h0000);
      put(32'h0);
      chk("irq masked", {31'h0, irq}, 32'h0);
   endtask

   // Entry: mode in [7:5], expected output in [4], gates 4..1 in [3:0]
   task automatic t_seq();
      logic [7:0] tbl [31] = '{8'h82, 8'h93, 8'h91, 8'h90, 8'h81, 8'h98, 8'h8C,
                              8'hAA, 8'hBB, 8'hB2, 8'hA3, 8'hA4,
                              8'hCA, 8'hDB, 8'hDA, 8'hCB, 8'hC2, 8'hD3, 8'hC4,
                              8'h72, 8'h70, 8'h64, 8'h60, 8'h65,
                              8'hF3, 8'hE1, 8'hE0, 8'hE2, 8'hF8, 8'hE4, 8'hF3};
      logic [2:0] md;
      md = 3'h0;
      foreach (tbl[i]) begin
         if (tbl[i][7:5] !== md) begin
            md = tbl[i][7:5];
            cfg(16'h8000 | {13'h0, md}, 16'h0000, 16'h3210, 16'h0802, 16'h8020);
         end
         put(vec(tbl[i][3:0]));
         chk("stored mode", {31'h0, cell_out}, {31'h0, tbl[i][4]});
      end
   endtask

   initial begin
      repeat (8) @(posedge pclk);
      presetn <= 1'h1;
      t_regs();
      t_comb();
      t_neg();
      t_sel();
      t_en();
      t_irq();
      t_seq();
      conclude();
   end
endmodule
